// [bench/tb.sv]
// Self-checking bench for the micro DMA controller core.
// Assumes the memory model above answers every bus access.
`timescale 1ns/1ps
module tb;
    import udma_pkg::*;
    logic clk = 0, rst = 1, slow = 0, eie = 1, cke = 1;
    logic [31:0] err_addr = 32'hffff_fffc;
    logic [NUM_CH-1:0] alt = 0, hi = 0, sw = 0, preq = 0, sreq = 0, act_seen;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, hburst;
    logic [3:0] hprot, st;
    logic hwrite, hready, hresp, derr, irq;
    logic [NUM_CH-1:0] act, done;
    int err_count = 0, samples_checked = 0;
    int ch_tab [4] = '{0, 7, 19, 20};
    logic [31:0] val_tab [4] = '{32'h1234_5678, 32'h0, 32'hffff_ffff,
                                 32'ha5c3_0f01};
    udma_ctrl u_dut (.clk(clk), .rst(rst), .sys_clk_en(cke),
        .master_en(1'b1), .err_irq_en(eie), .ctrl_base(32'h0),
        .chan_en({NUM_CH{1'b1}}), .chan_req_mask(21'h0),
        .chan_use_alt(alt), .chan_prio_hi(hi), .chan_use_burst(21'h0),
        .sw_req(sw), .per_req(preq), .per_sreq(sreq), .haddr(haddr),
        .htrans(htrans), .hsize(hsize), .hburst(hburst), .hprot(hprot),
        .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
        .hready(hready), .hresp(hresp), .dma_active(act),
        .dma_done(done), .dma_err(derr), .irq(irq), .dma_state(st));
    udma_mem_model u_mem (.clk(clk), .rst(rst), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .slow(slow),
        .err_addr(err_addr), .hrdata(hrdata), .hready(hready),
        .hresp(hresp));
    initial forever #2.5 clk = !clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_sim;
        $display("errors %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // Word-wide copy of 0x380 to 0x3c0, one element, basic cycle.
    task automatic setup(input int ch, input logic a, input logic [31:0] v);
        int b;
        b = (a ? 128 : 0) + ch * 4;
        u_mem.mem[b] = 32'h0000_0380;
        u_mem.mem[b + 1] = 32'h0000_03c0;
        u_mem.mem[b + 2] = 32'h8a00_0001;
        u_mem.mem[224] = v;
        u_mem.mem[240] = ~v;
    endtask : setup
    task automatic kick(input logic [NUM_CH-1:0] m);
        @(posedge clk) sw <= m;
        @(posedge clk) sw <= 0;
    endtask : kick
    task automatic wait_end;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if (done !== 0 || derr === 1'b1) return;
        end
        err_count++;
    endtask : wait_end
    always @(negedge clk) begin
        if (htrans === HTRANS_NONSEQ) begin
            cmp(hburst, HBURST_SINGLE);
            cmp(hsize, HSIZE_WORD);
        end
        if (act !== 0) act_seen = act;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        cmp(htrans, HTRANS_IDLE);
        cmp(st, CODE_IDLE);
        for (int r = 0; r < 4; r++) begin
            setup(ch_tab[r], r[0], val_tab[r]);
            @(posedge clk) alt <= r[0] ? 21'h1 << ch_tab[r] : 21'h0;
            act_seen = 0;
            kick(21'h1 << ch_tab[r]);
            wait_end;
            cmp(done, 21'h1 << ch_tab[r]);
            cmp(irq, 1'b1);
            cmp(act_seen, 21'h1 << ch_tab[r]);
            repeat (2) @(negedge clk);
            cmp(u_mem.mem[240], val_tab[r]);
            cmp(u_mem.mem[(r[0] ? 130 : 2) + ch_tab[r] * 4] & 7, 0);
        end
        alt <= 0;
        for (int p = 0; p < 2; p++) begin
            setup(2, 0, 32'h11);
            setup(9, 0, 32'h11);
            @(posedge clk) hi <= p ? 21'h200 : 21'h0;
            kick(21'h204);
            wait_end;
            cmp(done, p ? 21'h200 : 21'h4);
            wait_end;
            cmp(done, p ? 21'h4 : 21'h200);
        end
        setup(3, 0, 32'h22);
        err_addr <= 32'h380;
        kick(21'h8);
        wait_end;
        cmp(derr, 1'b1);
        cmp(done, 0);
        cmp(irq, 1'b1);
        err_addr <= 32'hffff_fffc;
        setup(11, 0, 32'h44);
        u_mem.mem[46] = 32'h8a00_4011;
        u_mem.mem[223] = 32'h55;
        kick(21'h800);
        wait_end;
        cmp(done, 21'h800);
        cmp(u_mem.mem[239], 32'h55);
        cmp(u_mem.mem[240], 32'h44);
        setup(6, 0, 32'h33);
        slow <= 1;
        @(posedge clk) preq <= 21'h40;
        repeat (120) @(negedge clk);
        cmp(st, CODE_WAIT_CLR);
        cmp(done, 0);
        @(posedge clk) preq <= 0;
        wait_end;
        cmp(done, 21'h40);
        cmp(u_mem.mem[240], 32'h33);
        setup(12, 0, 32'h77);
        @(posedge clk) cke <= 0;
        kick(21'h1000);
        repeat (20) @(negedge clk);
        cmp(act, 0);
        @(posedge clk) cke <= 1;
        wait_end;
        cmp(done, 21'h1000);
        setup(4, 0, 32'h66);
        @(posedge clk) sreq <= 21'h18;
        repeat (60) @(posedge clk);
        sreq <= 0;
        wait_end;
        cmp(done, 21'h10);
        cmp(u_mem.mem[240], 32'h66);
        end_sim;
    end
    initial begin
        #20000;
        err_count++;
        end_sim;
    end
endmodule : tb

// [bench/udma_mem_model.sv]
// AHB-Lite memory and bus matrix stand-in for the micro DMA bench.
// Assumes word accesses from one non-pipelined master on clk.
`timescale 1ns/1ps
module udma_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        slow,
    input  wire logic [31:0] err_addr,
    output logic [31:0]      hrdata,
    output logic             hready,
    output logic             hresp
);
    logic [31:0] mem [0:255];
    logic        dp_v;
    logic        dp_w;
    logic        e1;
    logic        tog;
    logic [31:0] dp_a;
    logic        dp_e;
    assign dp_e   = dp_v & (dp_a == err_addr);
    // An error answer takes two cycles; slow mode stalls every other one.
    assign hready = !(dp_e & !e1) & !(dp_v & slow & tog);
    assign hresp  = dp_e;
    // Idle read lines toggle so stale data is never mistaken for a reply.
    assign hrdata = (dp_v & !dp_w) ? mem[dp_a[9:2]] : {32{tog}};
    always_ff @(posedge clk) begin
        tog <= rst ? 1'b0 : !tog;
        if (rst) begin
            dp_v <= 1'b0;
            e1   <= 1'b0;
        end else if (hready) begin
            dp_v <= htrans[1];
            dp_a <= haddr;
            dp_w <= hwrite;
            e1   <= 1'b0;
            if (dp_v & dp_w & !dp_e) begin
                mem[dp_a[9:2]] <= hwdata;
            end
        end else if (dp_e) begin
            e1 <= 1'b1;
        end
    end
endmodule : udma_mem_model

// [common/udma_pkg.sv]
// Shared constants, control structure layout and state codes for the
// micro DMA controller.
// Assumes a single clock domain and a 32-bit single-transfer bus master.
package udma_pkg;

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    localparam int NUM_CH = 21;
    localparam int CH_W   = 5;

    // Fixed peripheral wiring: UART0 tx/rx 0/1, UART1 tx/rx 2/3,
    // SSP tx/rx 4/5, ADC 6, RTC 7, timer matches 8-13, comparators
    // 14-15, port pins 16-18, channels 19-20 spare.
    localparam logic [CH_W-1:0]   CH_SSP_TX = 5'h04;
    localparam logic [CH_W-1:0]   CH_SSP_RX = 5'h05;
    // Only the SSP channels 4 and 5 carry a single-transfer request.
    localparam logic [NUM_CH-1:0] SREQ_CAP  = 21'h00_0030;

    // ------------------------------------------------------------------
    // Control structure layout in memory
    // ------------------------------------------------------------------
    localparam int          SLOT_SHIFT  = 4;
    localparam logic [31:0] ALT_OFFSET  = 32'h0000_0200;
    localparam logic [31:0] OFS_SRC_END = 32'h0000_0000;
    localparam logic [31:0] OFS_DST_END = 32'h0000_0004;
    localparam logic [31:0] OFS_CTRL    = 32'h0000_0008;

    localparam int CC_LSB    = 0;
    localparam int NM1_LSB   = 4;
    localparam int RPOW_LSB  = 14;
    localparam int SSIZE_LSB = 24;
    localparam int SINC_LSB  = 26;
    localparam int DINC_LSB  = 30;

    localparam logic [2:0]  CYC_STOP   = 3'h0;
    localparam logic [2:0]  CYC_AUTO   = 3'h2;
    localparam logic [1:0]  INC_NONE   = 2'h3;
    localparam logic [3:0]  MAX_RPOW   = 4'ha;
    localparam logic [10:0] MAX_BURST  = 11'h400;
    localparam logic [10:0] ONE_BURST  = 11'h001;

    // ------------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HBURST_SINGLE = 3'h0;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic [3:0] HPROT_DATA    = 4'h1;

    // ------------------------------------------------------------------
    // Control state machine and its reported codes
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_RD_CTRL  = 9'h002,
        ST_RD_SRC   = 9'h004,
        ST_RD_DST   = 9'h008,
        ST_RD_DATA  = 9'h010,
        ST_WR_DATA  = 9'h020,
        ST_WAIT_CLR = 9'h040,
        ST_WR_CTRL  = 9'h080,
        ST_DONE     = 9'h100
    } udma_state_t;

    localparam logic [3:0] CODE_IDLE     = 4'h0;
    localparam logic [3:0] CODE_RD_CTRL  = 4'h1;
    localparam logic [3:0] CODE_RD_SRC   = 4'h2;
    localparam logic [3:0] CODE_RD_DST   = 4'h3;
    localparam logic [3:0] CODE_RD_DATA  = 4'h4;
    localparam logic [3:0] CODE_WR_DATA  = 4'h5;
    localparam logic [3:0] CODE_WAIT_CLR = 4'h6;
    localparam logic [3:0] CODE_WR_CTRL  = 4'h7;
    localparam logic [3:0] CODE_DONE     = 4'h8;

endpackage : udma_pkg

// [src/udma_arb.sv]
// Channel arbiter for the micro DMA controller.
// Assumes pending requests are already synchronised and masked.
`timescale 1ns/1ps
module udma_arb
    import udma_pkg::*;
(
    input  wire logic [NUM_CH-1:0] pend,
    input  wire logic [NUM_CH-1:0] prio_hi,
    output logic                   found,
    output logic [CH_W-1:0]        idx
);

    // ------------------------------------------------------------------
    // Lowest set channel number
    // ------------------------------------------------------------------
    function automatic logic [CH_W:0] first_set(
        input logic [NUM_CH-1:0] v
    );
        logic [CH_W:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, CH_W'(i)};
            end
        end
        return r;
    endfunction : first_set

    logic [CH_W:0] hi_pick;
    logic [CH_W:0] any_pick;

    // High level first, then fixed order on channel number.
    assign hi_pick  = first_set(pend & prio_hi);
    assign any_pick = first_set(pend);
    assign found    = any_pick[CH_W];
    assign idx      = hi_pick[CH_W] ? hi_pick[CH_W-1:0]
                                    : any_pick[CH_W-1:0];

endmodule : udma_arb

// [src/udma_ctrl.sv]
// Micro DMA controller core: arbitration, control structure fetch,
// element moves over a single-transfer bus master, and completion.
// Assumes configuration arrives on plain inputs held stable by the
// system, and peripheral requests arrive asynchronously on pins.
`timescale 1ns/1ps
module udma_ctrl
    import udma_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sys_clk_en,
    input  wire logic              master_en,
    input  wire logic              err_irq_en,
    input  wire logic [31:0]       ctrl_base,
    input  wire logic [NUM_CH-1:0] chan_en,
    input  wire logic [NUM_CH-1:0] chan_req_mask,
    input  wire logic [NUM_CH-1:0] chan_use_alt,
    input  wire logic [NUM_CH-1:0] chan_prio_hi,
    input  wire logic [NUM_CH-1:0] chan_use_burst,
    input  wire logic [NUM_CH-1:0] sw_req,
    input  wire logic [NUM_CH-1:0] per_req,
    input  wire logic [NUM_CH-1:0] per_sreq,
    output logic [31:0]            haddr,
    output logic [1:0]             htrans,
    output logic [2:0]             hsize,
    output logic [2:0]             hburst,
    output logic [3:0]             hprot,
    output logic                   hwrite,
    output logic [31:0]            hwdata,
    input  wire logic [31:0]       hrdata,
    input  wire logic              hready,
    input  wire logic              hresp,
    output logic [NUM_CH-1:0]      dma_active,
    output logic [NUM_CH-1:0]      dma_done,
    output logic                   dma_err,
    output logic                   irq,
    output logic [3:0]             dma_state
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [NUM_CH-1:0] ch_mask(input logic [CH_W-1:0] c);
        return NUM_CH'(1) << c;
    endfunction : ch_mask

    function automatic logic [31:0] elem_addr(
        input logic [31:0] end_a,
        input logic [9:0]  n,
        input logic [1:0]  inc
    );
        logic [31:0] off;
        off = {22'h0, n} << inc;
        return (inc == INC_NONE) ? end_a : end_a - off;
    endfunction : elem_addr

    function automatic logic [3:0] state_code(input udma_state_t s);
        logic [3:0] c;
        c = CODE_IDLE;
        unique case (s)
            ST_IDLE:     c = CODE_IDLE;
            ST_RD_CTRL:  c = CODE_RD_CTRL;
            ST_RD_SRC:   c = CODE_RD_SRC;
            ST_RD_DST:   c = CODE_RD_DST;
            ST_RD_DATA:  c = CODE_RD_DATA;
            ST_WR_DATA:  c = CODE_WR_DATA;
            ST_WAIT_CLR: c = CODE_WAIT_CLR;
            ST_WR_CTRL:  c = CODE_WR_CTRL;
            ST_DONE:     c = CODE_DONE;
            default:     c = CODE_IDLE;
        endcase
        return c;
    endfunction : state_code

    // ------------------------------------------------------------------
    // Request pins, two flip-flop synchronisers
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] req_m_q, req_s_q, sreq_m_q, sreq_s_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            req_m_q  <= '0;
            req_s_q  <= '0;
            sreq_m_q <= '0;
            sreq_s_q <= '0;
        end else begin
            req_m_q  <= per_req;
            req_s_q  <= req_m_q;
            sreq_m_q <= per_sreq;
            sreq_s_q <= sreq_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Pending requests and arbitration
    // ------------------------------------------------------------------
    udma_state_t       state_q;
    logic [CH_W-1:0]   ch_q;
    logic [NUM_CH-1:0] sw_pend_q, auto_pend_q;
    logic [NUM_CH-1:0] hw_req, soft_req, pend;
    logic              arb_found;
    logic [CH_W-1:0]   arb_idx;
    logic              start;

    // Each channel serves one peripheral, so one side is always memory.
    assign hw_req   = req_s_q
                      | (sreq_s_q & SREQ_CAP & ~chan_use_burst);
    assign soft_req = sw_pend_q | auto_pend_q;
    assign pend     = chan_en & ((hw_req & ~chan_req_mask) | soft_req);
    // New work is only taken with the system clock enable set.
    assign start    = (state_q == ST_IDLE) & sys_clk_en & master_en
                      & arb_found;

    udma_arb u_arb (
        .pend    (pend),
        .prio_hi (chan_prio_hi),
        .found   (arb_found),
        .idx     (arb_idx)
    );

    // A software request arriving in the grant cycle is kept.
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_pend_q <= '0;
        end else begin
            sw_pend_q <= (sw_pend_q & ~(start ? ch_mask(arb_idx) : '0))
                         | sw_req;
        end
    end

    // ------------------------------------------------------------------
    // Bus master address and data
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q, src_end_q, dst_end_q, data_q, hwdata_q;
    logic [9:0]  n_q;
    logic        alt_q, ph_q;
    logic        cyc_done_q;
    logic [31:0] slot, src_addr, dst_addr, ctrl_wb, rd_lane;
    logic [31:0] bus_addr, bus_wdata;
    logic [2:0]  bus_size;
    logic        bus_wr, bus_state, issue, addr_ok, data_ok;
    logic [1:0]  ssize;

    assign ssize    = ctrl_q[SSIZE_LSB +: 2];
    // Primary and alternate structures sit at fixed offsets from base.
    assign slot     = ctrl_base + (alt_q ? ALT_OFFSET : 32'h0)
                      + ({27'h0, ch_q} << SLOT_SHIFT);
    assign src_addr = elem_addr(src_end_q, n_q, ctrl_q[SINC_LSB +: 2]);
    assign dst_addr = elem_addr(dst_end_q, n_q, ctrl_q[DINC_LSB +: 2]);
    assign rd_lane  = hrdata >> {src_addr[1:0], 3'b000};

    always_comb begin
        ctrl_wb = ctrl_q;
        ctrl_wb[NM1_LSB +: 10] = n_q;
        if (cyc_done_q) begin
            ctrl_wb[CC_LSB +: 3] = CYC_STOP;
        end
    end

    always_comb begin
        bus_addr  = slot + OFS_CTRL;
        bus_size  = HSIZE_WORD;
        bus_wr    = 1'b0;
        bus_wdata = 32'h0;
        unique case (state_q)
            ST_RD_CTRL: bus_addr = slot + OFS_CTRL;
            ST_RD_SRC:  bus_addr = slot + OFS_SRC_END;
            ST_RD_DST:  bus_addr = slot + OFS_DST_END;
            ST_RD_DATA: begin
                bus_addr = src_addr;
                bus_size = {1'b0, ssize};
            end
            ST_WR_DATA: begin
                bus_addr = dst_addr;
                bus_size = {1'b0, ssize};
                bus_wr   = 1'b1;
                unique case (ssize)
                    2'h0:    bus_wdata = {4{data_q[7:0]}};
                    2'h1:    bus_wdata = {2{data_q[15:0]}};
                    default: bus_wdata = data_q;
                endcase
            end
            ST_WR_CTRL: begin
                bus_addr  = slot + OFS_CTRL;
                bus_wr    = 1'b1;
                bus_wdata = ctrl_wb;
            end
            ST_IDLE, ST_WAIT_CLR, ST_DONE: bus_wr = 1'b0;
            default: bus_wr = 1'b0;
        endcase
    end

    assign bus_state = state_q inside {ST_RD_CTRL, ST_RD_SRC, ST_RD_DST,
                                       ST_RD_DATA, ST_WR_DATA, ST_WR_CTRL};
    assign issue   = bus_state & ~ph_q;
    assign addr_ok = issue & hready;
    assign data_ok = ph_q & hready;

    assign haddr  = bus_addr;
    assign htrans = issue ? HTRANS_NONSEQ : HTRANS_IDLE;
    assign hsize  = bus_size;
    assign hburst = HBURST_SINGLE;
    assign hprot  = HPROT_DATA;
    assign hwrite = bus_wr;
    assign hwdata = hwdata_q;

    // One transfer at a time: address phase, then its data phase.
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q     <= 1'b0;
            hwdata_q <= 32'h0;
        end else if (addr_ok) begin
            ph_q     <= 1'b1;
            hwdata_q <= bus_wdata;
        end else if (data_ok) begin
            ph_q     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control state machine
    // ------------------------------------------------------------------
    logic [10:0] burst_left_q;
    logic        from_hw_q, single_q;
    logic        ch_req;

    assign ch_req = req_s_q[ch_q] | sreq_s_q[ch_q];

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q      <= ST_IDLE;
            ch_q         <= '0;
            alt_q        <= 1'b0;
            from_hw_q    <= 1'b0;
            single_q     <= 1'b0;
            cyc_done_q   <= 1'b0;
            ctrl_q       <= 32'h0;
            src_end_q    <= 32'h0;
            dst_end_q    <= 32'h0;
            data_q       <= 32'h0;
            n_q          <= '0;
            burst_left_q <= '0;
        end else if (data_ok && hresp) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: if (start) begin
                    state_q    <= ST_RD_CTRL;
                    ch_q       <= arb_idx;
                    alt_q      <= chan_use_alt[arb_idx];
                    from_hw_q  <= ~soft_req[arb_idx];
                    single_q   <= ~soft_req[arb_idx] & ~req_s_q[arb_idx];
                    cyc_done_q <= 1'b0;
                end
                ST_RD_CTRL: if (data_ok) begin
                    ctrl_q  <= hrdata;
                    state_q <= (hrdata[CC_LSB +: 3] == CYC_STOP)
                               ? ST_IDLE : ST_RD_SRC;
                end
                ST_RD_SRC: if (data_ok) begin
                    src_end_q <= hrdata;
                    state_q   <= ST_RD_DST;
                end
                ST_RD_DST: if (data_ok) begin
                    dst_end_q <= hrdata;
                    n_q       <= ctrl_q[NM1_LSB +: 10];
                    if (single_q) begin
                        burst_left_q <= ONE_BURST;
                    end else if (ctrl_q[RPOW_LSB +: 4] >= MAX_RPOW) begin
                        burst_left_q <= MAX_BURST;
                    end else begin
                        burst_left_q <= ONE_BURST << ctrl_q[RPOW_LSB +: 4];
                    end
                    state_q <= ST_RD_DATA;
                end
                ST_RD_DATA: if (data_ok) begin
                    data_q  <= rd_lane;
                    state_q <= ST_WR_DATA;
                end
                ST_WR_DATA: if (data_ok) begin
                    if (n_q == 10'h0) begin
                        cyc_done_q <= 1'b1;
                        state_q    <= ST_WR_CTRL;
                    end else begin
                        n_q <= n_q - 10'h1;
                        if (burst_left_q == ONE_BURST) begin
                            state_q <= ST_WR_CTRL;
                        end else begin
                            burst_left_q <= burst_left_q - ONE_BURST;
                            state_q      <= ST_RD_DATA;
                        end
                    end
                end
                ST_WR_CTRL: if (data_ok) begin
                    state_q <= from_hw_q ? ST_WAIT_CLR : ST_DONE;
                end
                ST_WAIT_CLR: if (!ch_req) begin
                    state_q <= ST_DONE;
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Auto cycles keep their channel pending until the count runs out.
    always_ff @(posedge clk) begin
        if (rst) begin
            auto_pend_q <= '0;
        end else if (state_q == ST_DONE && !cyc_done_q
                     && ctrl_q[CC_LSB +: 3] == CYC_AUTO) begin
            auto_pend_q <= auto_pend_q | ch_mask(ch_q);
        end else if (start) begin
            auto_pend_q <= auto_pend_q & ~ch_mask(arb_idx);
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] done_q;
    logic              err_q;
    logic [3:0]        status_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            done_q   <= '0;
            err_q    <= 1'b0;
            status_q <= CODE_IDLE;
        end else begin
            done_q   <= (state_q == ST_DONE && cyc_done_q)
                        ? ch_mask(ch_q) : '0;
            err_q    <= data_ok & hresp;
            status_q <= state_code(state_q);
        end
    end

    assign dma_active = (state_q != ST_IDLE) ? ch_mask(ch_q) : '0;
    assign dma_done   = done_q;
    assign dma_err    = err_q;
    assign irq        = (|done_q) | (err_q & err_irq_en);
    assign dma_state  = status_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence clear_seen;
        state_q == ST_WAIT_CLR && !ch_req;
    endsequence

    sequence finish_seq;
        state_q == ST_DONE ##1 state_q == ST_IDLE;
    endsequence

    single_burst_a: assert property (hburst == HBURST_SINGLE)
        else $error("burst type other than single issued");

    ctrl_word_a: assert property (
        issue && (state_q inside {ST_RD_CTRL, ST_RD_SRC, ST_RD_DST,
                                  ST_WR_CTRL}) |-> hsize == HSIZE_WORD)
        else $error("control structure access not word sized");

    data_size_a: assert property (
        issue && (state_q inside {ST_RD_DATA, ST_WR_DATA})
        |-> hsize == {1'b0, ctrl_q[SSIZE_LSB +: 2]})
        else $error("element size differs from control field");

    hold_off_a: assert property (
        state_q == ST_WAIT_CLR && ch_req |=> state_q == ST_WAIT_CLR)
        else $error("cycle completed while request held");

    clear_done_a: assert property (clear_seen |=> finish_seq)
        else $error("request release not followed by completion");

    bus_error_a: assert property (
        data_ok && hresp |=> dma_err && state_q == ST_IDLE ##1 !dma_err)
        else $error("bus error not flagged for one cycle");

    irq_done_a: assert property ((|dma_done) |-> irq)
        else $error("done without interrupt");

    arb_order_a: assert property (
        start && (|(pend & chan_prio_hi)) |-> chan_prio_hi[arb_idx]
        && ((pend & chan_prio_hi & (ch_mask(arb_idx) - NUM_CH'(1))) == '0))
        else $error("high level channel lost arbitration");

    multi_xfer_a: assert property (
        state_q == ST_WR_DATA && data_ok && !hresp && n_q != 10'h0
        && burst_left_q > ONE_BURST |=> state_q == ST_RD_DATA && issue)
        else $error("multi transfer did not continue");

    clk_gate_a: assert property (
        state_q == ST_IDLE && !sys_clk_en |=> state_q == ST_IDLE)
        else $error("work started with clock enable cleared");

    status_code_a: assert property (
        state_q == ST_WAIT_CLR |=> dma_state == CODE_WAIT_CLR)
        else $error("status code does not follow state");

endmodule : udma_ctrl
